// >>> dv/card_ctrl_assertions.sv
// concurrent checks on the serial control block ports
`timescale 1ns/100ps
module card_ctrl_checker (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // serial port
   input wire logic serial_clk,
   input wire logic serial_in,
   input wire logic load_strobe,
   input wire logic serial_out,
   // status sources
   input wire logic supply_ready_a,
   input wire logic efault_a,
   input wire logic efault_b,
   input wire logic atr_fault_a,
   input wire logic atr_fault_b,
   // supplies
   input wire logic [1:0] socket_a_supply,
   input wire logic [1:0] socket_b_supply,
   input wire logic shutdown,
   // open drain pins
   input wire logic host_data_in,
   input wire logic host_data_oe_n,
   input wire logic card_io_a_oe_n,
   input wire logic card_io_b_oe_n,
   input wire logic fault_oe_n
);
   // ==========================================
   // shadow of shift path and command latch
   logic sclk_reg, ld_reg, ok_reg, ok_next, shift_ev, fall_ev, flt, io_ok;
   logic [4:0] cnt_reg, cnt_next; // shifts since strobe low
   logic [15:0] sh_reg, sh_next, cmd_reg, cmd_next;
   assign shift_ev = serial_clk & ~sclk_reg & load_strobe;
   assign fall_ev = ld_reg & ~load_strobe;
   assign flt = efault_a | efault_b | atr_fault_a | atr_fault_b;
   assign io_ok = ok_reg & cmd_reg[10] & (cmd_reg[12:11] == 2'h3)
      & (cmd_reg[9:8] != 2'h0) & supply_ready_a & ~efault_a;
   // next shadow values
   always_comb begin
      sh_next = shift_ev ? {sh_reg[14:0], serial_in} : sh_reg;
      cmd_next = fall_ev ? sh_reg : cmd_reg;
      ok_next = fall_ev ? (cnt_reg == 5'h10) : ok_reg;
      cnt_next = cnt_reg;
      if (!load_strobe) begin
         cnt_next = 5'h00;
      end else if (shift_ev && cnt_reg != 5'h10) begin
         cnt_next = cnt_reg + 5'h01;
      end
   end
   // shadow registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sclk_reg <= 1'b1;
         ld_reg <= 1'b1;
         ok_reg <= 1'b1;
         cnt_reg <= 5'h00;
         sh_reg <= 16'h0000;
         cmd_reg <= card_ctrl_pkg::control_reset;
      end else begin
         sclk_reg <= serial_clk;
         ld_reg <= load_strobe;
         ok_reg <= ok_next;
         cnt_reg <= cnt_next;
         sh_reg <= sh_next;
         cmd_reg <= cmd_next;
      end
   end
   // ==========================================
   // assertions
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // command latch with no fault near it
   sequence s_latch_a;
      !efault_a ##1 (fall_ev && !efault_a) ##1 !efault_a ##1 !efault_a;
   endsequence
   sequence s_latch_b;
      !efault_b ##1 (fall_ev && !efault_b) ##1 !efault_b ##1 !efault_b;
   endsequence
   AST_SHIFT_HOLD: assert property (
      load_strobe && ld_reg && !shift_ev |=> $stable(serial_out))
      else $error("serial out moved");
   AST_SHUTDOWN: assert property (
      fall_ev && (cnt_reg == 5'h10) |-> ##2 (shutdown ==
      (cmd_reg[9:8] == 2'h0 && cmd_reg[1:0] == 2'h0)))
      else $error("shutdown wrong");
   AST_CMD_HOLD: assert property (
      !fall_ev ##1 !fall_ev |=> $stable(shutdown))
      else $error("shutdown moved");
   AST_SUPPLY_A: assert property (
      s_latch_a |-> !ok_reg || socket_a_supply == cmd_reg[9:8])
      else $error("supply a wrong");
   AST_SUPPLY_B: assert property (
      s_latch_b |-> !ok_reg || socket_b_supply == cmd_reg[1:0])
      else $error("supply b wrong");
   AST_EFAULT_OFF: assert property (
      efault_b |-> ##[1:3] (socket_b_supply == 2'h0))
      else $error("supply b kept");
   AST_FAULT_SET: assert property (
      flt [*3] |-> !fault_oe_n)
      else $error("fault pin released");
   AST_FAULT_CLR: assert property (
      !flt [*3] |-> fault_oe_n)
      else $error("fault pin pulled");
   AST_DESEL_FLOAT: assert property (
      (ok_reg && !cmd_reg[2] && !cmd_reg[10]) [*3] |->
      (host_data_oe_n && card_io_a_oe_n && card_io_b_oe_n))
      else $error("pin pulled while deselected");
   AST_PASS_LOW: assert property (
      (io_ok && host_data_oe_n && !host_data_in) [*3] |-> !card_io_a_oe_n)
      else $error("host low not passed");
endmodule
bind dual_card_serial_control card_ctrl_checker u_card_ctrl_checker (
   .clk, .sys_rst, .serial_clk, .serial_in, .load_strobe, .serial_out,
   .supply_ready_a, .efault_a, .efault_b, .atr_fault_a, .atr_fault_b,
   .socket_a_supply, .socket_b_supply, .shutdown, .host_data_in,
   .host_data_oe_n, .card_io_a_oe_n, .card_io_b_oe_n, .fault_oe_n
);

// >>> dv/host_serial_model.sv
// host side serial master model
`timescale 1ns/100ps
module host_serial_model (
   // clock
   input wire logic clk,
   // serial port
   input wire logic serial_out,
   output logic serial_clk,
   output logic serial_in,
   output logic load_strobe
);
   // idle with clock and strobe high
   initial begin
      serial_clk = 1'b1;
      serial_in = 1'b0;
      load_strobe = 1'b1;
   end
   // wait some system clock edges
   task automatic gap(input int n);
      repeat (n) @(posedge clk);
   endtask
   // move the strobe, clock stays high
   task automatic set_load(input logic v);
      load_strobe <= v;
      gap(3);
   endtask
   // word msb first with status read back
   task automatic xfer(input logic [15:0] cmd, output logic [15:0] rx);
      for (int i = 15; i >= 0; i--) begin
         rx[i] = serial_out;
         serial_clk <= 1'b0;
         serial_in <= cmd[i];
         gap(2); // 100 ns half period
         serial_clk <= 1'b1;
         gap(2);
      end
      set_load(1'b0);
      set_load(1'b1);
   endtask
endmodule

// >>> dv/test_dual_card_serial_control.sv
// self-checking bench for the dual card serial control block
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_dual_card_serial_control;
   // ==========================================
   // signals
   logic clk, sys_rst, serial_clk, serial_in, load_strobe, serial_out;
   logic present_a, present_b, supply_ready_a, supply_ready_b;
   logic efault_a, efault_b, atr_fault_a, atr_fault_b, shutdown;
   logic sync_clock_in, free_running_clock_in, host_reset_in;
   logic card_clk_a, card_clk_b, card_rst_a, card_rst_b;
   logic socket_a_aux4, socket_a_aux8, fault_oe_n, host_pull, card_a_pull;
   logic host_data_in, host_data_out, host_data_oe_n;
   logic card_io_a_in, card_io_a_out, card_io_a_oe_n;
   logic card_io_b_in, card_io_b_out, card_io_b_oe_n;
   logic [1:0] socket_a_supply, socket_b_supply;
   logic [15:0] rx;
   logic [2:0] pins;
   int mismatches = 0, n_checks = 0, w;
   // rows: command, status, expected supplies, shutdown
   typedef struct packed {
      logic [15:0] cmd;
      logic [5:0] st; // present, ready, atr for a then b
      logic [1:0] sup_a;
      logic [1:0] sup_b;
      logic down;
   } row_s;
   row_s rows [6] = '{'{16'h0000, 6'h00, 2'h0, 2'h0, 1'b1},
      '{16'h0101, 6'h24, 2'h1, 2'h1, 1'b0},
      '{16'h0203, 6'h12, 2'h2, 2'h3, 1'b0},
      '{16'h0302, 6'h09, 2'h3, 2'h2, 1'b0},
      '{16'hbe00, 6'h36, 2'h2, 2'h0, 1'b0},
      '{16'h0001, 6'h3f, 2'h0, 2'h1, 1'b0}};
   logic [2:0] modes [3] = '{card_ctrl_pkg::clk_stop_high,
      card_ctrl_pkg::clk_sync, card_ctrl_pkg::clk_stop_low};
   logic [2:0] clk_exp = 3'b001; // sync follows a low sync input
   // open drain wires, low when any party pulls
   assign host_data_in = host_data_oe_n & ~host_pull;
   assign card_io_a_in = card_io_a_oe_n & ~card_a_pull;
   assign card_io_b_in = card_io_b_oe_n;
   // ==========================================
   // block and host model
   dual_card_serial_control u_dual_card_serial_control (.clk, .sys_rst,
      .serial_clk, .serial_in, .load_strobe, .serial_out, .present_a,
      .present_b, .supply_ready_a, .supply_ready_b, .efault_a, .efault_b,
      .atr_fault_a, .atr_fault_b, .socket_a_supply, .socket_b_supply,
      .shutdown, .sync_clock_in, .free_running_clock_in, .host_reset_in,
      .card_clk_a, .card_clk_b, .card_rst_a, .card_rst_b, .socket_a_aux4,
      .socket_a_aux8, .host_data_in, .host_data_out, .host_data_oe_n,
      .card_io_a_in, .card_io_a_out, .card_io_a_oe_n, .card_io_b_in,
      .card_io_b_out, .card_io_b_oe_n, .fault_oe_n);
   host_serial_model u_host (.clk, .serial_out, .serial_clk, .serial_in,
      .load_strobe);
   // system clock and free running card clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) free_running_clock_in <= ~free_running_clock_in;
   // verdict and end of run
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ==========================================
   // main sequence
   initial begin
      {present_a, present_b, supply_ready_a, supply_ready_b} = 4'h0;
      {efault_a, efault_b, atr_fault_a, atr_fault_b} = 4'h0;
      {sync_clock_in, free_running_clock_in, host_reset_in} = 3'b100;
      {host_pull, card_a_pull} = 2'b00;
      sys_rst = 1'b1;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      u_host.gap(2);
      // card a clock modes
      foreach (modes[m]) begin
         sync_clock_in <= ~m[0];
         u_host.xfer({modes[m], 13'h0600}, rx);
         u_host.gap(40);
         `CHK(card_clk_a, clk_exp[m])
      end
      $display("clock modes done");
      // ordinary commands, status read on the second transfer
      foreach (rows[i]) begin
         {present_a, supply_ready_a, atr_fault_a, present_b, supply_ready_b,
            atr_fault_b} <= rows[i].st;
         u_host.xfer(rows[i].cmd, rx);
         `CHK(socket_a_supply, rows[i].sup_a)
         `CHK(socket_b_supply, rows[i].sup_b)
         `CHK(shutdown, rows[i].down)
         u_host.xfer(rows[i].cmd, rx);
         `CHK(rx, {rows[i].st[5:3], 5'h00, rows[i].st[2:0], 5'h00})
      end
      $display("table rows done");
      // electrical faults on card b then card a while both cards run
      {present_a, supply_ready_a, atr_fault_a, present_b, supply_ready_b,
         atr_fault_b} <= 6'h00;
      u_host.xfer(16'h0303, rx);
      efault_b <= 1'b1;
      u_host.gap(4);
      `CHK(socket_b_supply, card_ctrl_pkg::supply_off)
      `CHK(socket_a_supply, card_ctrl_pkg::supply_5v)
      `CHK(fault_oe_n, 1'b0)
      u_host.xfer(16'h0303, rx);
      {efault_a, efault_b} <= 2'b10;
      u_host.gap(4);
      `CHK(socket_a_supply, card_ctrl_pkg::supply_off)
      efault_a <= 1'b0;
      u_host.xfer(16'h0303, rx);
      `CHK(rx, 16'h0010)
      `CHK(socket_b_supply, card_ctrl_pkg::supply_5v)
      `CHK(fault_oe_n, 1'b1)
      $display("fault test done");
      // card a routing of the host data pin
      supply_ready_a <= 1'b1;
      for (int r = 1; r < 4; r++) begin
         u_host.xfer({3'h0, r[1:0], 1'b1, 2'h2, 8'h00}, rx);
         for (int lv = 0; lv < 2; lv++) begin
            host_pull <= ~lv[0];
            u_host.gap(4);
            pins = {card_io_a_oe_n, socket_a_aux8, socket_a_aux4};
            `CHK(pins[r - 1], lv[0])
         end
      end
      card_a_pull <= 1'b1;
      host_reset_in <= 1'b1; // only card a selected
      u_host.gap(4);
      `CHK(host_data_oe_n, 1'b0)
      `CHK(card_rst_a, 1'b1)
      u_host.xfer(16'h0200, rx);
      host_reset_in <= 1'b0;
      u_host.gap(4);
      `CHK(host_data_oe_n, 1'b1)
      `CHK(card_io_a_oe_n, 1'b1)
      `CHK(card_rst_a, 1'b1)
      card_a_pull <= 1'b0;
      $display("data path done");
      // strobe low: out follows card a presence
      present_a <= 1'b1;
      u_host.set_load(1'b0);
      for (w = 0; w < 8 && serial_out !== 1'b1; w++) u_host.gap(1);
      if (w == 8) begin
         mismatches++;
         finish_test();
      end
      `CHK(serial_out, 1'b1)
      u_host.set_load(1'b1);
      present_a <= 1'b0;
      u_host.gap(4);
      `CHK(serial_out, 1'b1)
      $display("transparency done");
      // reset in mid run returns to shutdown
      sys_rst <= 1'b1;
      u_host.gap(2);
      `CHK(shutdown, 1'b1)
      `CHK(socket_a_supply, card_ctrl_pkg::supply_off)
      sys_rst <= 1'b0;
      u_host.gap(3);
      u_host.xfer(16'h0000, rx);
      `CHK(shutdown, 1'b1)
      $display("reset test done");
      finish_test();
   end
endmodule

// >>> inc/card_ctrl_pkg.sv
// field layout and codes of the card serial control
package card_ctrl_pkg;
   // ==========================================
   // word geometry
   localparam int word_w = 16;
   localparam logic [15:0] control_reset = 16'h0000;
   // ==========================================
   // control word fields
   localparam int ctl_supply_b_lo = 0;
   localparam int ctl_select_b = 2;
   localparam int ctl_clock_b_lo = 5;
   localparam int ctl_supply_a_lo = 8;
   localparam int ctl_select_a = 10;
   localparam int ctl_route_a_lo = 11;
   localparam int ctl_clock_a_lo = 13;
   // ==========================================
   // status word fields
   localparam int st_efault_b = 4;
   localparam int st_atr_b = 5;
   localparam int st_ready_b = 6;
   localparam int st_present_b = 7;
   localparam int st_efault_a = 12;
   localparam int st_atr_a = 13;
   localparam int st_ready_a = 14;
   localparam int st_present_a = 15;
   // ==========================================
   // supply codes
   localparam logic [1:0] supply_off = 2'h0;
   localparam logic [1:0] supply_1v8 = 2'h1;
   localparam logic [1:0] supply_3v = 2'h2;
   localparam logic [1:0] supply_5v = 2'h3;
   // ==========================================
   // clock mode codes
   localparam logic [2:0] clk_sync = 3'h0;
   localparam logic [2:0] clk_unused = 3'h1;
   localparam logic [2:0] clk_stop_low = 3'h2;
   localparam logic [2:0] clk_stop_high = 3'h3;
   localparam logic [2:0] clk_div1 = 3'h4;
   localparam logic [2:0] clk_div2 = 3'h5;
   localparam logic [2:0] clk_div4 = 3'h6;
   localparam logic [2:0] clk_div8 = 3'h7;
   // ==========================================
   // card a routing codes
   localparam logic [1:0] route_none = 2'h0;
   localparam logic [1:0] route_aux4 = 2'h1;
   localparam logic [1:0] route_aux8 = 2'h2;
   localparam logic [1:0] route_io = 2'h3;
   // ==========================================
   // serial timing limit
   localparam int sys_clk_hz = 20000000;
   localparam int serial_clk_max_hz = 10000000;
   localparam int sys_cycles_per_serial = sys_clk_hz / serial_clk_max_hz;
endpackage

// >>> rtl/card_clock_channel.sv
// one card clock channel: follow, divide or stop
`timescale 1ns/100ps
module card_clock_channel (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // control
   input wire logic [2:0] mode,
   input wire logic selected,
   input wire logic active,
   // clock sources
   input wire logic sync_level,
   input wire logic free_level,
   input wire logic free_rise,
   // card clock
   output logic card_clk
);
   logic [2:0] div_reg; // divider on free running edges
   logic [2:0] div_next;
   logic clk_reg; // card clock flop
   logic clk_next;

   // ==========================================
   // next state of divider and card clock
   always_comb begin
      div_next = div_reg;
      clk_next = clk_reg;
      if (free_rise) begin
         div_next = div_reg + 3'h1;
      end
      if (!active) begin
         // channel deactivated: clock low
         clk_next = 1'b0;
      end else begin
         case (mode)
            card_ctrl_pkg::clk_sync: begin
               // follow sync only when selected
               if (selected) begin
                  clk_next = sync_level;
               end
            end
            card_ctrl_pkg::clk_stop_low: clk_next = 1'b0;
            card_ctrl_pkg::clk_stop_high: clk_next = 1'b1;
            card_ctrl_pkg::clk_div1: clk_next = free_level;
            card_ctrl_pkg::clk_div2: clk_next = div_reg[0];
            card_ctrl_pkg::clk_div4: clk_next = div_reg[1];
            card_ctrl_pkg::clk_div8: clk_next = div_reg[2];
            default: clk_next = clk_reg; // unused code holds
         endcase
      end
   end

   // ==========================================
   // registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_reg <= 3'h0;
         clk_reg <= 1'b0;
      end else begin
         div_reg <= div_next;
         clk_reg <= clk_next;
      end
   end

   assign card_clk = clk_reg;
endmodule

// >>> rtl/dual_card_serial_control.sv
// serial command and status port with card a and b channel control
`timescale 1ns/100ps
// Overview of operation
// - sample input on serial clock rise, msb first
// - status bit presented on each serial clock rise
// - load strobe fall copies shift into command
// - strobe low: shift register follows live status
// - strobe rise freezes status for next transfer
// - serial out feeds next unit's serial in
// - two supply bits pick 0, 1.8, 3, 5 volts
// - both supplies off means overall shutdown
// - clock field picks sync, stop or divide
// - power-up puts both clocks in sync mode
// - select bit makes card a data candidate
// - deselected card idles high, host side floats
// - card a route bits pick nothing, aux4, aux8, io
// - status has presence bits, fixed zero bits
// - supply ready reported, gates card communication
// - electrical and answer_to_reset faults reported
// - electrical fault deactivates card automatically
// - low on either side passes to other
// - open-drain fault output on any fault bit
// - reset pin follows host reset when selected
module dual_card_serial_control (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // serial port
   input wire logic serial_clk,
   input wire logic serial_in,
   input wire logic load_strobe,
   output logic serial_out,
   // card status sources
   input wire logic present_a,
   input wire logic present_b,
   input wire logic supply_ready_a,
   input wire logic supply_ready_b,
   input wire logic efault_a,
   input wire logic efault_b,
   input wire logic atr_fault_a,
   input wire logic atr_fault_b,
   // supply control
   output logic [1:0] socket_a_supply,
   output logic [1:0] socket_b_supply,
   output logic shutdown,
   // clock and reset sources
   input wire logic sync_clock_in,
   input wire logic free_running_clock_in,
   input wire logic host_reset_in,
   // card pins
   output logic card_clk_a,
   output logic card_clk_b,
   output logic card_rst_a,
   output logic card_rst_b,
   output logic socket_a_aux4,
   output logic socket_a_aux8,
   // host data pin, open drain
   input wire logic host_data_in,
   output logic host_data_out,
   output logic host_data_oe_n,
   // card io pins, open drain
   input wire logic card_io_a_in,
   output logic card_io_a_out,
   output logic card_io_a_oe_n,
   input wire logic card_io_b_in,
   output logic card_io_b_out,
   output logic card_io_b_oe_n,
   // fault pin, open drain
   output logic fault_oe_n
);
   // ==========================================
   // edge detection of the synchronous pins
   logic sclk_prev_reg; // serial clock one cycle ago
   logic load_prev_reg; // load strobe one cycle ago
   logic free_prev_reg; // free running clock one cycle ago
   logic sclk_rise;
   logic load_fall;
   logic free_rise;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sclk_prev_reg <= 1'b1;
         load_prev_reg <= 1'b1;
         free_prev_reg <= 1'b0;
      end else begin
         sclk_prev_reg <= serial_clk;
         load_prev_reg <= load_strobe;
         free_prev_reg <= free_running_clock_in;
      end
   end

   assign sclk_rise = serial_clk & ~sclk_prev_reg;
   assign load_fall = ~load_strobe & load_prev_reg;
   assign free_rise = free_running_clock_in & ~free_prev_reg;

   // ==========================================
   // status word assembly
   logic [15:0] status_word; // live card status
   always_comb begin
      status_word = 16'h0000; // fixed zero positions
      status_word[card_ctrl_pkg::st_present_a] = present_a;
      status_word[card_ctrl_pkg::st_present_b] = present_b;
      status_word[card_ctrl_pkg::st_ready_a] = supply_ready_a;
      status_word[card_ctrl_pkg::st_ready_b] = supply_ready_b;
      status_word[card_ctrl_pkg::st_efault_a] = efault_a;
      status_word[card_ctrl_pkg::st_efault_b] = efault_b;
      status_word[card_ctrl_pkg::st_atr_a] = atr_fault_a;
      status_word[card_ctrl_pkg::st_atr_b] = atr_fault_b;
   end

   // ==========================================
   // shift register, command latch, fault lockout
   logic [15:0] shift_reg; // serial shift stage
   logic [15:0] shift_next;
   logic [15:0] cmd_reg; // applied command word
   logic [15:0] cmd_next;
   logic sout_reg; // serial output flop
   logic sout_next;
   logic lock_a_reg; // card a shut by electrical fault
   logic lock_a_next;
   logic lock_b_reg; // card b shut by electrical fault
   logic lock_b_next;

   always_comb begin
      shift_next = shift_reg;
      cmd_next = cmd_reg; // held through shifting
      lock_a_next = lock_a_reg;
      lock_b_next = lock_b_reg;
      if (!load_strobe) begin
         // transparent to live status
         shift_next = status_word;
      end else if (sclk_rise) begin
         // msb first shift in
         shift_next = {shift_reg[14:0], serial_in};
      end
      // strobe fall copies shift into command
      if (load_fall) begin
         cmd_next = shift_reg;
         // a new command lifts the fault lockout
         lock_a_next = 1'b0;
         lock_b_next = 1'b0;
      end
      // fault set wins over clear
      if (efault_a) begin
         lock_a_next = 1'b1;
      end
      if (efault_b) begin
         lock_b_next = 1'b1;
      end
      // out bit is shift msb
      sout_next = shift_next[15];
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         shift_reg <= 16'h0000;
         cmd_reg <= card_ctrl_pkg::control_reset; // sync mode
         sout_reg <= 1'b0;
         lock_a_reg <= 1'b0;
         lock_b_reg <= 1'b0;
      end else begin
         shift_reg <= shift_next;
         cmd_reg <= cmd_next;
         sout_reg <= sout_next;
         lock_a_reg <= lock_a_next;
         lock_b_reg <= lock_b_next;
      end
   end

   // ==========================================
   // command field decode
   logic [1:0] sup_a_cmd; // card a supply code
   logic [1:0] sup_b_cmd; // card b supply code
   logic [2:0] mode_a; // card a clock mode
   logic [2:0] mode_b; // card b clock mode
   logic [1:0] route_a; // card a data routing
   logic sel_a; // card a selected
   logic sel_b; // card b selected
   logic act_a; // card a powered and not locked
   logic act_b; // card b powered and not locked
   logic comm_a; // card a may talk
   logic comm_b; // card b may talk

   assign sup_a_cmd = cmd_reg[card_ctrl_pkg::ctl_supply_a_lo +: 2];
   assign sup_b_cmd = cmd_reg[card_ctrl_pkg::ctl_supply_b_lo +: 2];
   assign mode_a = cmd_reg[card_ctrl_pkg::ctl_clock_a_lo +: 3];
   assign mode_b = cmd_reg[card_ctrl_pkg::ctl_clock_b_lo +: 3];
   assign route_a = cmd_reg[card_ctrl_pkg::ctl_route_a_lo +: 2];
   assign sel_a = cmd_reg[card_ctrl_pkg::ctl_select_a];
   assign sel_b = cmd_reg[card_ctrl_pkg::ctl_select_b];
   // supply code off deactivates the channel
   assign act_a = (sup_a_cmd != card_ctrl_pkg::supply_off) & ~lock_a_reg;
   assign act_b = (sup_b_cmd != card_ctrl_pkg::supply_off) & ~lock_b_reg;
   // talk needs select and ready
   assign comm_a = sel_a & act_a & supply_ready_a;
   assign comm_b = sel_b & act_b & supply_ready_b;

   // ==========================================
   // card clock channels
   card_clock_channel u_clock_a (
      .clk(clk),
      .sys_rst(sys_rst),
      .mode(mode_a),
      .selected(sel_a),
      .active(act_a),
      .sync_level(sync_clock_in),
      .free_level(free_running_clock_in),
      .free_rise(free_rise),
      .card_clk(card_clk_a)
   );

   card_clock_channel u_clock_b (
      .clk(clk),
      .sys_rst(sys_rst),
      .mode(mode_b),
      .selected(sel_b),
      .active(act_b),
      .sync_level(sync_clock_in),
      .free_level(free_running_clock_in),
      .free_rise(free_rise),
      .card_clk(card_clk_b)
   );

   // ==========================================
   // supply, reset, data path and fault pins
   logic [1:0] sup_a_reg; // card a supply drive
   logic [1:0] sup_a_next;
   logic [1:0] sup_b_reg; // card b supply drive
   logic [1:0] sup_b_next;
   logic shdn_reg; // overall shutdown
   logic shdn_next;
   logic rst_a_reg; // card a reset pin
   logic rst_a_next;
   logic rst_b_reg; // card b reset pin
   logic rst_b_next;
   logic aux4_reg; // card a aux4 pin
   logic aux4_next;
   logic aux8_reg; // card a aux8 pin
   logic aux8_next;
   logic host_low_reg; // pulling host data low
   logic host_low_next;
   logic io_a_low_reg; // pulling card a io low
   logic io_a_low_next;
   logic io_b_low_reg; // pulling card b io low
   logic io_b_low_next;
   logic fault_reg; // fault pin asserted
   logic fault_next;
   logic io_a_path; // card a io routed to host
   logic card_a_pulls; // card a io low from the card side
   logic card_b_pulls; // card b io low from the card side
   logic host_pulls; // host data low from the host side

   assign io_a_path = comm_a & (route_a == card_ctrl_pkg::route_io);
   // our own low must not echo back
   assign card_a_pulls = io_a_path & ~card_io_a_in & ~io_a_low_reg;
   assign card_b_pulls = comm_b & ~card_io_b_in & ~io_b_low_reg;
   assign host_pulls = ~host_data_in & ~host_low_reg;

   always_comb begin
      sup_a_next = act_a ? sup_a_cmd : card_ctrl_pkg::supply_off;
      sup_b_next = act_b ? sup_b_cmd : card_ctrl_pkg::supply_off;
      // both fields off gives shutdown
      shdn_next = (sup_a_cmd == card_ctrl_pkg::supply_off) &
                  (sup_b_cmd == card_ctrl_pkg::supply_off);
      // reset follows host when selected
      rst_a_next = rst_a_reg;
      rst_b_next = rst_b_reg;
      if (!act_a) begin
         rst_a_next = 1'b0;
      end else if (sel_a) begin
         rst_a_next = host_reset_in;
      end
      if (!act_b) begin
         rst_b_next = 1'b0;
      end else if (sel_b) begin
         rst_b_next = host_reset_in;
      end
      // aux pins follow host data
      aux4_next = aux4_reg;
      aux8_next = aux8_reg;
      if (!act_a) begin
         aux4_next = 1'b0;
         aux8_next = 1'b0;
      end else if (comm_a) begin
         if (route_a == card_ctrl_pkg::route_aux4) begin
            aux4_next = host_data_in;
         end
         if (route_a == card_ctrl_pkg::route_aux8) begin
            aux8_next = host_data_in;
         end
      end
      // low passes either way, released otherwise
      io_a_low_next = io_a_path & host_pulls;
      io_b_low_next = comm_b & host_pulls;
      // deselected cards leave host side floating
      host_low_next = card_a_pulls | card_b_pulls;
      // any fault bit drives the fault pin
      fault_next = efault_a | efault_b | atr_fault_a | atr_fault_b;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sup_a_reg <= card_ctrl_pkg::supply_off;
         sup_b_reg <= card_ctrl_pkg::supply_off;
         shdn_reg <= 1'b1;
         rst_a_reg <= 1'b0;
         rst_b_reg <= 1'b0;
         aux4_reg <= 1'b0;
         aux8_reg <= 1'b0;
         host_low_reg <= 1'b0;
         io_a_low_reg <= 1'b0;
         io_b_low_reg <= 1'b0;
         fault_reg <= 1'b0;
      end else begin
         sup_a_reg <= sup_a_next;
         sup_b_reg <= sup_b_next;
         shdn_reg <= shdn_next;
         rst_a_reg <= rst_a_next;
         rst_b_reg <= rst_b_next;
         aux4_reg <= aux4_next;
         aux8_reg <= aux8_next;
         host_low_reg <= host_low_next;
         io_a_low_reg <= io_a_low_next;
         io_b_low_reg <= io_b_low_next;
         fault_reg <= fault_next;
      end
   end

   // ==========================================
   // output pins from flops, data out pins tied low
   assign serial_out = sout_reg;
   assign socket_a_supply = sup_a_reg;
   assign socket_b_supply = sup_b_reg;
   assign shutdown = shdn_reg;
   assign card_rst_a = rst_a_reg;
   assign card_rst_b = rst_b_reg;
   assign socket_a_aux4 = aux4_reg;
   assign socket_a_aux8 = aux8_reg;
   assign host_data_out = 1'b0;
   assign host_data_oe_n = ~host_low_reg;
   assign card_io_a_out = 1'b0;
   assign card_io_a_oe_n = ~io_a_low_reg;
   assign card_io_b_out = 1'b0;
   assign card_io_b_oe_n = ~io_b_low_reg;
   assign fault_oe_n = ~fault_reg;
endmodule
